//--- adccs_defs.vh
// constants for the converter sequencer and serial output block
`ifndef ADCCS_DEFS_VH
`define ADCCS_DEFS_VH

// ==========================================
// timing
`define ADCCS_CLK_NS 10
`define ADCCS_CONV_TICKS 10255
`define ADCCS_CONV60_NS 66600000
`define ADCCS_CONV50_NS 80000000
`define ADCCS_TICK60_CYC ((`ADCCS_CONV60_NS / `ADCCS_CLK_NS) / `ADCCS_CONV_TICKS)
`define ADCCS_TICK50_CYC ((`ADCCS_CONV50_NS / `ADCCS_CLK_NS) / `ADCCS_CONV_TICKS)
`define ADCCS_SCK_DIV 8
`define ADCCS_DOUT_BITS 32
`define ADCCS_DOUT_MAX_NS 1670000
`define ADCCS_DOUT_TICKS (`ADCCS_DOUT_BITS * `ADCCS_SCK_DIV)
`define ADCCS_EXT_MIN_HZ 2560
`define ADCCS_EXT_TIMEOUT_CYC ((1000000000 / `ADCCS_CLK_NS) / `ADCCS_EXT_MIN_HZ)
`define ADCCS_INIT_WAIT 2'h3

// ==========================================
// register map
`define ADCCS_CTRL_OFS 4'h0
`define ADCCS_STATUS_OFS 4'h4
`define ADCCS_FRAME_OFS 4'h8
`define ADCCS_CTRL_FORCE_INT 0
`define ADCCS_ST_EOC_N 0
`define ADCCS_ST_STATE_LO 1
`define ADCCS_ST_EXT_CLK 3
`define ADCCS_ST_HOST_SCK 4
`define ADCCS_CTRL_RST 1'b0
`define ADCCS_RESP_OKAY 2'h0
`define ADCCS_RESP_SLVERR 2'h2

// ==========================================
// frame codes
`define ADCCS_CODE_OVER 30'h30000000
`define ADCCS_CODE_UNDER 30'h0fffffff

`endif

//--- adccs_sync.v
// two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ns
module adccs_sync #(
    parameter WIDTH = 1
) (
    input wire clk,
    input wire rstn,
    input wire [WIDTH-1:0] din,
    output reg [WIDTH-1:0] dout
);

// ==========================================
// first stage feeds only the second
reg [WIDTH-1:0] meta;

always @(posedge clk) begin
    if (!rstn) begin
        meta <= {WIDTH{1'b0}};
        dout <= {WIDTH{1'b0}};
    end else begin
        meta <= din;
        dout <= meta;
    end
end

endmodule

//--- adccs_clksrc.v
// conversion clock source: internal notch timing or detected external clock
`timescale 1ns/1ns
`include "adccs_defs.vh"
module adccs_clksrc #(
    parameter EXT_TIMEOUT = `ADCCS_EXT_TIMEOUT_CYC
) (
    input wire clk,
    input wire rstn,
    input wire fsel,
    input wire force_int,
    output reg conv_tick,
    output reg ext_active
);

localparam [31:0] TICK60_W = `ADCCS_TICK60_CYC;
localparam [31:0] TICK50_W = `ADCCS_TICK50_CYC;
localparam [31:0] TIMEOUT_W = EXT_TIMEOUT;
localparam [9:0] TICK60 = TICK60_W[9:0];
localparam [9:0] TICK50 = TICK50_W[9:0];
localparam [16:0] TIMEOUT = TIMEOUT_W[16:0];

reg fsel_d;
reg seen_edge;
reg [16:0] gap_cnt;
reg [9:0] osc_cnt;
wire fsel_rise = fsel & ~fsel_d;
wire [9:0] osc_end = fsel ? TICK50 - 10'h001 : TICK60 - 10'h001;

// ==========================================
// external clock detection
always @(posedge clk) begin
    if (!rstn) begin
        fsel_d <= 1'b0;
        seen_edge <= 1'b0;
        gap_cnt <= 17'h00000;
        ext_active <= 1'b0;
    end else begin
        fsel_d <= fsel;
        if (fsel_rise) begin
            gap_cnt <= 17'h00000;
            seen_edge <= 1'b1;
            // two rising edges closer than the slowest legal period
            if (seen_edge && !force_int)
                ext_active <= 1'b1;
        end else if (gap_cnt >= TIMEOUT) begin
            seen_edge <= 1'b0;
            ext_active <= 1'b0;
        end else begin
            gap_cnt <= gap_cnt + 17'h00001;
        end
        if (force_int)
            ext_active <= 1'b0;
    end
end

// ==========================================
// tick generation; a notch change only retimes the running count
always @(posedge clk) begin
    if (!rstn) begin
        osc_cnt <= 10'h000;
        conv_tick <= 1'b0;
    end else if (ext_active) begin
        osc_cnt <= 10'h000;
        conv_tick <= fsel_rise;
    end else if (osc_cnt >= osc_end) begin
        osc_cnt <= 10'h000;
        conv_tick <= 1'b1;
    end else begin
        osc_cnt <= osc_cnt + 10'h001;
        conv_tick <= 1'b0;
    end
end

endmodule

//--- adccs_top.v
// conversion sequencer, serial frame output and axi4-lite registers
`timescale 1ns/1ns
`include "adccs_defs.vh"
module adccs_top #(
    parameter ADDR_W = 4,
    parameter CONV_TICKS = `ADCCS_CONV_TICKS,
    parameter EXT_TIMEOUT = `ADCCS_EXT_TIMEOUT_CYC
) (
    input wire clk,
    input wire rstn,
    input wire notch_clock_select,
    input wire cs_n,
    input wire sck_in,
    output reg sck_out,
    output reg sck_oe,
    output reg sdo_out,
    output reg sdo_oe,
    input wire [29:0] conv_value,
    input wire conv_over,
    input wire conv_under,
    output reg conv_start,
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);

// ==========================================
// states
localparam [1:0] ST_CONV = 2'h0;
localparam [1:0] ST_SLEEP = 2'h1;
localparam [1:0] ST_DOUT = 2'h2;
localparam [31:0] CONV_LAST_W = CONV_TICKS - 1;
localparam [31:0] LAST_BIT_W = `ADCCS_DOUT_BITS - 1;
localparam [13:0] CONV_LAST = CONV_LAST_W[13:0];
localparam [5:0] LAST_BIT = LAST_BIT_W[5:0];

// ==========================================
// pin synchronisation
wire [2:0] pins_s;
wire s_fsel = pins_s[2];
// select synced inverted so reset reads as deselected, no stray drive
wire s_cs_n = ~pins_s[1];
wire s_sck = pins_s[0];

adccs_sync #(
    .WIDTH(3)
) u_sync (
    .clk(clk),
    .rstn(rstn),
    .din({notch_clock_select, ~cs_n, sck_in}),
    .dout(pins_s)
);

reg ctrl_force_int;
wire conv_tick;
wire ext_active;

adccs_clksrc #(
    .EXT_TIMEOUT(EXT_TIMEOUT)
) u_clksrc (
    .clk(clk),
    .rstn(rstn),
    .fsel(s_fsel),
    .force_int(ctrl_force_int),
    .conv_tick(conv_tick),
    .ext_active(ext_active)
);

// ==========================================
// edge detection on synchronised pins
reg cs_n_d;
reg sck_d;
wire cs_fall = cs_n_d & ~s_cs_n;
wire cs_rise = ~cs_n_d & s_cs_n;
wire ext_rise = ~sck_d & s_sck & ~s_cs_n;
wire ext_fall = sck_d & ~s_sck & ~s_cs_n;

always @(posedge clk) begin
    if (!rstn) begin
        cs_n_d <= 1'b1;
        sck_d <= 1'b0;
    end else begin
        cs_n_d <= s_cs_n;
        sck_d <= s_sck;
    end
end

// ==========================================
// serial clock mode decision
reg host_sck;
reg [1:0] init_cnt;
reg init_done;
// pin enable follows the mode decided this cycle, else one stale drive pulse
wire next_host_sck = (init_done && cs_fall) ? ~s_sck : host_sck;

// waits for the synchroniser to fill before trusting the pin
always @(posedge clk) begin
    if (!rstn) begin
        host_sck <= 1'b0;
        init_cnt <= 2'h0;
        init_done <= 1'b0;
    end else begin
        if (!init_done) begin
            if (init_cnt == `ADCCS_INIT_WAIT) begin
                init_done <= 1'b1;
                host_sck <= ~s_sck;
            end else begin
                init_cnt <= init_cnt + 2'h1;
            end
        end else if (cs_fall) begin
            host_sck <= ~s_sck;
        end
    end
end

// ==========================================
// sequencer
reg [1:0] state;
reg [1:0] next_state;
reg [13:0] conv_cnt;
reg [13:0] next_conv_cnt;
reg [31:0] frame;
reg [31:0] next_frame;
reg [31:0] frame_last;
reg [5:0] bit_cnt;
reg [5:0] next_bit_cnt;
reg sck_gen;
reg next_sck_gen;
reg [1:0] div_cnt;
reg [1:0] next_div_cnt;
reg [29:0] code;
wire int_fall = conv_tick & (div_cnt == 2'h3) & sck_gen;
wire shift_ev = host_sck ? ext_fall : int_fall;

always @* begin
    if (conv_over)
        code = `ADCCS_CODE_OVER;
    else if (conv_under)
        code = `ADCCS_CODE_UNDER;
    else
        code = {~conv_value[29], conv_value[28:0]};
end

always @* begin
    next_state = state;
    next_conv_cnt = conv_cnt;
    next_frame = frame;
    next_bit_cnt = bit_cnt;
    next_sck_gen = sck_gen;
    next_div_cnt = div_cnt;
    case (state)
        ST_CONV: begin
            if (conv_tick) begin
                if (conv_cnt == CONV_LAST) begin
                    next_state = ST_SLEEP;
                    next_frame = {1'b0, 1'b0, code};
                end else begin
                    next_conv_cnt = conv_cnt + 14'h0001;
                end
            end
        end
        ST_SLEEP: begin
            next_bit_cnt = 6'h00;
            next_div_cnt = 2'h0;
            next_sck_gen = 1'b0;
            if (!s_cs_n && host_sck && ext_rise)
                next_state = ST_DOUT;
            else if (!s_cs_n && !host_sck && !cs_fall)
                next_state = ST_DOUT;
        end
        ST_DOUT: begin
            if (s_cs_n || cs_rise) begin
                next_state = ST_CONV;
                next_conv_cnt = 14'h0000;
            end else begin
                if (!host_sck && conv_tick) begin
                    next_div_cnt = div_cnt + 2'h1;
                    if (div_cnt == 2'h3)
                        next_sck_gen = ~sck_gen;
                end
                if (shift_ev) begin
                    next_frame = {frame[30:0], 1'b1};
                    next_bit_cnt = bit_cnt + 6'h01;
                    if (bit_cnt == LAST_BIT) begin
                        next_state = ST_CONV;
                        next_conv_cnt = 14'h0000;
                    end
                end
            end
        end
        default: begin
            next_state = ST_CONV;
            next_conv_cnt = 14'h0000;
        end
    endcase
end

always @(posedge clk) begin
    if (!rstn) begin
        state <= ST_CONV;
        conv_cnt <= 14'h0000;
        frame <= 32'h00000000;
        frame_last <= 32'h00000000;
        bit_cnt <= 6'h00;
        sck_gen <= 1'b0;
        div_cnt <= 2'h0;
        conv_start <= 1'b0;
    end else begin
        state <= next_state;
        conv_cnt <= next_conv_cnt;
        frame <= next_frame;
        bit_cnt <= next_bit_cnt;
        sck_gen <= next_sck_gen;
        div_cnt <= next_div_cnt;
        conv_start <= (state != ST_CONV) && (next_state == ST_CONV);
        if (state == ST_CONV && next_state == ST_SLEEP)
            frame_last <= next_frame;
    end
end

// ==========================================
// pin drivers, all registered
always @(posedge clk) begin
    if (!rstn) begin
        sdo_out <= 1'b1;
        sdo_oe <= 1'b0;
        sck_out <= 1'b1;
        sck_oe <= 1'b0;
    end else begin
        // eoc high while converting, frame msb otherwise
        sdo_out <= (next_state == ST_CONV) ? 1'b1 : next_frame[31];
        sdo_oe <= ~s_cs_n;
        // idle high so the pin reads as self-clocked when released
        sck_out <= (next_state == ST_DOUT) ? next_sck_gen : 1'b1;
        sck_oe <= ~next_host_sck & ~s_cs_n & init_done;
    end
end

// ==========================================
// axi4-lite write channel
reg aw_full;
reg w_full;
reg [ADDR_W-1:0] aw_addr;
reg [31:0] w_data;
reg [3:0] w_strb;

always @(posedge clk) begin
    if (!rstn) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        aw_addr <= {ADDR_W{1'b0}};
        w_data <= 32'h00000000;
        w_strb <= 4'h0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `ADCCS_RESP_OKAY;
        ctrl_force_int <= `ADCCS_CTRL_RST;
    end else begin
        if (s_axi_awvalid && s_axi_awready) begin
            aw_full <= 1'b1;
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_full <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end
        if (aw_full && w_full && !s_axi_bvalid) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (aw_addr[3:0] == `ADCCS_CTRL_OFS) begin
                s_axi_bresp <= `ADCCS_RESP_OKAY;
                if (w_strb[0])
                    ctrl_force_int <= w_data[`ADCCS_CTRL_FORCE_INT];
            end else if (aw_addr[3:0] == `ADCCS_STATUS_OFS ||
                         aw_addr[3:0] == `ADCCS_FRAME_OFS) begin
                s_axi_bresp <= `ADCCS_RESP_OKAY;
            end else begin
                s_axi_bresp <= `ADCCS_RESP_SLVERR;
            end
        end
        if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end
    end
end

// ==========================================
// axi4-lite read channel
reg [31:0] rd_mux;
reg rd_err;

always @* begin
    rd_mux = 32'h00000000;
    rd_err = 1'b0;
    case (s_axi_araddr[3:0])
        `ADCCS_CTRL_OFS: rd_mux[`ADCCS_CTRL_FORCE_INT] = ctrl_force_int;
        `ADCCS_STATUS_OFS: begin
            rd_mux[`ADCCS_ST_EOC_N] = (state == ST_CONV);
            rd_mux[`ADCCS_ST_STATE_LO+1:`ADCCS_ST_STATE_LO] = state;
            rd_mux[`ADCCS_ST_EXT_CLK] = ext_active;
            rd_mux[`ADCCS_ST_HOST_SCK] = host_sck;
        end
        `ADCCS_FRAME_OFS: rd_mux = frame_last;
        default: rd_err = 1'b1;
    endcase
end

always @(posedge clk) begin
    if (!rstn) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `ADCCS_RESP_OKAY;
    end else begin
        if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_err ? `ADCCS_RESP_SLVERR : `ADCCS_RESP_OKAY;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
end

endmodule

//--- adccs_props.sv
// concurrent checks on the sequencer and serial output ports
`timescale 1ns/1ns
module adccs_props #(
    parameter ADDR_W = 4
) (
    input wire clk,
    input wire rstn,
    input wire cs_n,
    input wire sck_in,
    input wire sck_out,
    input wire sck_oe,
    input wire sdo_out,
    input wire sdo_oe,
    input wire conv_start,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    // ==========================================
    // serial pins
    // five samples: select passes two sync stages and the output register
    sdo_hiz_a: assert property (cs_n [*5] |=> !sdo_oe)
        else $error("data pin driven with select high");
    sck_rel_a: assert property (cs_n [*5] |=> !sck_oe)
        else $error("clock pin driven with select high");
    host_mode_a: assert property ((!sck_in && $fell(cs_n) && !sck_oe) |=> !sck_oe [*6])
        else $error("clock driven after select fell with clock low");
    self_mode_a: assert property ((sck_in && $fell(cs_n)) ##1 !cs_n [*4] |=> sck_oe)
        else $error("clock not driven after select fell with clock high");
    rise_hold_a: assert property (!sck_oe && sdo_oe && sck_in && $past(sck_in)
        && $past(sck_in, 2) && $past(sck_in, 3) |-> $stable(sdo_out))
        else $error("data bit moved while host clock high");
    eoc_start_a: assert property (conv_start && sdo_oe |-> sdo_out)
        else $error("data pin low as conversion starts");
    sck_half_a: assert property ($rose(sck_out) && sck_oe |=> sck_out [*8])
        else $error("self clock high phase too short");
    // ==========================================
    // register bus
    wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    rd_unmap_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 4'hc
        |=> s_axi_rresp == 2'h2)
        else $error("unmapped read not refused");
    rd_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data held after acceptance");
endmodule
bind adccs_top adccs_props #(.ADDR_W(ADDR_W)) i_adccs_props (
    .clk, .rstn, .cs_n, .sck_in, .sck_out, .sck_oe, .sdo_out, .sdo_oe, .conv_start,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready
);

//--- adccs_host.sv
// host controller model on the select, serial clock and data pins
`timescale 1ns/1ns
module adccs_host (
    input wire clk,
    input wire sdo,
    input wire sck,
    output logic cs_n,
    output logic sck_drv,
    output logic sck_en
);
    initial begin
        cs_n = 1'b1;
        sck_drv = 1'b0;
        sck_en = 1'b1;
    end
    // ==========================================
    // host clocked read, nb bits then stop
    task automatic xfer_host(input int nb, output logic [31:0] f);
        f = 32'h0;
        @(posedge clk);
        cs_n <= 1'b1;
        sck_en <= 1'b1;
        sck_drv <= 1'b0;
        // clock settles low well before select falls
        repeat (8) @(posedge clk);
        cs_n <= 1'b0;
        repeat (8) @(posedge clk);
        while (sdo !== 1'b0) @(posedge clk);
        for (int i = 0; i < nb; i++) begin
            sck_drv <= 1'b1;
            repeat (8) @(posedge clk);
            f = {f[30:0], sdo};
            sck_drv <= 1'b0;
            repeat (8) @(posedge clk);
        end
    endtask
    // ==========================================
    // self clocked read, samples on rising clock
    task automatic xfer_self(output logic [31:0] f, output int per);
        logic p;
        time t0;
        f = 32'h0;
        t0 = 0;
        @(posedge clk);
        cs_n <= 1'b1;
        sck_en <= 1'b0;
        repeat (8) @(posedge clk);
        cs_n <= 1'b0;
        for (int i = 0; i < 32; i++) begin
            do begin
                p = sck;
                @(negedge clk);
            end while (!(sck === 1'b1 && p === 1'b0));
            f = {f[30:0], sdo};
            if (i == 0) t0 = $time;
            if (i == 1) per = int'(($time - t0) / 10);
        end
    endtask
    task set_cs(input logic v);
        @(posedge clk);
        cs_n <= v;
    endtask
    task wiggle(input int n);
        repeat (n) begin
            @(posedge clk);
            sck_drv <= ~sck_drv;
        end
    endtask
endmodule

//--- tb_top.sv
// self-checking bench for the converter sequencer block
`timescale 1ns/1ns
module tb_top;
    localparam int CT = 20;
    localparam int ET = 200;
    logic clk = 1'b0, rstn = 1'b0, fsel = 1'b0, ext_on = 1'b0, sdo_q = 1'b0;
    logic [29:0] cval = 30'h0;
    logic c_ov = 1'b0, c_un = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    wire cs_n, sck_drv, sck_en, sck_out, sck_oe, sdo_out, sdo_oe, conv_start;
    wire awready, wready, bvalid, arready, rvalid;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    // undriven clock pin pulls high; undriven data pin keeps changing
    wire sck_w = sck_oe ? sck_out : (sck_en ? sck_drv : 1'b1);
    wire sdo_w = sdo_oe ? sdo_out : ~sdo_q;
    int n_mismatch = 0, tests_run = 0, ec = 0;
    logic [31:0] xp [4] = '{32'h1fffffff, 32'h30000000, 32'h0fffffff, 32'h2aaaaaaa};
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        sdo_q <= sdo_w;
        if (ext_on) begin
            ec <= (ec == 9) ? 0 : ec + 1;
            if (ec == 9) fsel <= ~fsel;
        end
    end
    adccs_top #(.CONV_TICKS(CT), .EXT_TIMEOUT(ET)) i_adccs_top (
        .clk(clk), .rstn(rstn), .notch_clock_select(fsel), .cs_n(cs_n), .sck_in(sck_w),
        .sck_out(sck_out), .sck_oe(sck_oe), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
        .conv_value(cval), .conv_over(c_ov), .conv_under(c_un), .conv_start(conv_start),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    adccs_host i_adccs_host (.clk(clk), .sdo(sdo_w), .sck(sck_w), .cs_n(cs_n),
        .sck_drv(sck_drv), .sck_en(sck_en));
    // ==========================================
    // helpers
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task final_report;
        $display("mismatches %0d checks %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask
    task axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task st(input string nm, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(4'h4, d, r);
        chk(nm, d & m, e);
    endtask
    // conversion length, tick phase allows one tick short
    task t_conv(input int exp, input string nm);
        int n;
        n = 0;
        while (sdo_out !== 1'b0) begin
            @(posedge clk);
            n++;
        end
        chk(nm, (n >= exp - exp / CT - 20 && n <= exp + 20), 32'h1);
    endtask
    // ==========================================
    // scenarios
    task t_regs;
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(4'h0, d, r);
        chk("ctrl reset", d, 32'h0);
        axi_rd(4'hc, d, r);
        chk("unmapped read", r, 32'h2);
        axi_wr(4'hc, 32'h1, r);
        chk("unmapped write", r, 32'h2);
        axi_wr(4'h0, 32'h1, r);
        axi_rd(4'h0, d, r);
        chk("ctrl readback", d, 32'h1);
        axi_wr(4'h0, 32'h0, r);
        st("status sleep", 32'h7, 32'h2);
    endtask
    task t_codes;
        logic [31:0] f;
        for (int k = 0; k < 4; k++) begin
            i_adccs_host.xfer_host(32, f);
            chk("frame", f, xp[k]);
            c_ov <= (k == 0);
            c_un <= (k == 1);
            cval <= 30'h0aaaaaaa;
            chk("eoc after frame", sdo_w, 32'h1);
        end
    endtask
    task t_self;
        logic [31:0] f;
        int per;
        i_adccs_host.xfer_self(f, per);
        chk("self frame", f, 32'h2aaaaaaa);
        chk("self clock period", per, 32'd160);
        st("self mode", 32'h10, 32'h0);
    endtask
    task t_abort;
        logic [31:0] f;
        int n;
        i_adccs_host.xfer_host(5, f);
        chk("partial bits", f[4:0], 32'h5);
        i_adccs_host.set_cs(1'b1);
        n = 0;
        while (conv_start !== 1'b1 && n < 12) begin
            @(posedge clk);
            n++;
        end
        chk("abort restart", conv_start, 32'h1);
        st("abort state", 32'h16, 32'h10);
    endtask
    task t_ignore;
        while (sdo_out !== 1'b0) @(posedge clk);
        i_adccs_host.wiggle(8);
        st("clock ignored", 32'h7, 32'h2);
    endtask
    // ==========================================
    // main sequence and watchdog
    initial begin
        logic [31:0] f;
        logic [1:0] r;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        t_conv(CT * 6660000 / 10255, "conv 60hz");
        t_regs;
        fsel <= 1'b1;
        i_adccs_host.xfer_host(32, f);
        chk("zero frame", f, 32'h20000000);
        cval <= 30'h3fffffff;
        t_conv(CT * 8000000 / 10255, "conv 50hz");
        ext_on <= 1'b1;
        t_codes;
        t_conv(CT * 20, "conv ext");
        st("ext host mode", 32'h18, 32'h18);
        axi_wr(4'h0, 32'h1, r);
        st("ext forced off", 32'h8, 32'h0);
        axi_wr(4'h0, 32'h0, r);
        t_self;
        t_abort;
        t_ignore;
        ext_on <= 1'b0;
        repeat (ET + 60) @(posedge clk);
        st("ext lost", 32'h8, 32'h0);
        final_report;
    end
    initial begin
        repeat (90000) @(posedge clk);
        n_mismatch++;
        $display("ERROR watchdog expired");
        final_report;
    end
endmodule
